// ### verilog/lsc_pkg.sv
// package: register map, field layout and modes of the low-speed clock source control
package lsc_pkg;
  localparam int AXI_AW = 20;
  // register indices; byte address is four times the index
  localparam logic [17:0] IDX_CTRL = 18'h0F004;
  localparam logic [17:0] IDX_STAT = 18'h0F00A;
  localparam logic [17:0] IDX_AUX = 18'h0F00C;
  localparam logic [15:0] CTRL_RST = 16'h0002;
  localparam logic [7:0] STAT_RST = 8'h06;
  localparam logic AUX_RST = 1'b0;
  localparam int MODE_LSB = 0;
  localparam int LFLT_BIT = 4;
  localparam int HFLT_LSB = 6;
  localparam int HSRC_BIT = 1;
  localparam int LSRC_BIT = 2;
  localparam int PERMIT_BIT = 0;
  localparam int RC_START_CNT = 128;
  localparam int XTAL_STAB_CNT = 8192;
  localparam int EXT_EDGE_CNT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LM_HOLD = 2'b00,
    LM_XTAL = 2'b01,
    LM_RC = 2'b10,
    LM_EXT = 2'b11
  } lsc_lmode_t;

  typedef enum logic [1:0] {
    HF_OFF = 2'b00,
    HF_ONE = 2'b01,
    HF_TWO = 2'b10,
    HF_OFF2 = 2'b11
  } lsc_hflt_t;

  typedef enum logic [2:0] {
    LS_RC_WAIT = 3'b000,
    LS_RC = 3'b001,
    LS_XTAL_STAB = 3'b010,
    LS_XTAL = 3'b011,
    LS_EXT_CNT = 3'b100,
    LS_EXT = 3'b101
  } lsc_state_t;

  // power-down state of the chip
  typedef struct packed {
    logic stopMode;
    logic deepSleepState;
    logic haltHighMode;
  } lsc_pwr_t;

  // high-speed side as seen by the status logic
  typedef struct packed {
    logic [1:0] highModeSel;
    logic highXtalStable;
  } lsc_hs_t;
endpackage

// ### verilog/lsc_low_clock_ctrl.sv
// low-speed clock source control: registers, source sequencer and status
// Functional notes
// - writing 00 to the low mode select leaves the held mode unchanged.
// - mode 01 crystal, 10 RC, 11 external input; reset to RC.
// - bit 4 turns the low noise filter on in crystal or external mode.
// - bits 7:6 pick high filter off, one, two, off; forced off while the high clock mode is RC.
// - control register takes byte or halfword writes, resets to 0002H.
// - status register is read-only, resets to 06H, unused bits zero.
// - high source flag is 0 when running from crystal or external input.
// - high flag is 1 in RC mode and while crystal is stopped or stabilising.
// - high flag goes 1 in stop, deep sleep or halt-high modes.
// - low source flag is 0 only when running from crystal or external input.
// - low source flag goes 1 on entering stop mode.
// - RC clock is withheld from peripherals until 128 RC cycles pass.
// - after 8192 crystal cycles switch to crystal and raise switch event.
// - after 16 input edges switch to external input and raise switch event.
// - permit bit runs the crystal in RC mode, feeding only the timer.
`timescale 1ns/1ps
`default_nettype none
module lsc_low_clock_ctrl #(
  parameter int XtalStabCount = lsc_pkg::XTAL_STAB_CNT,
  parameter int RcStartCount = lsc_pkg::RC_START_CNT,
  parameter int ExtEdgeCount = lsc_pkg::EXT_EDGE_CNT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [lsc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lsc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rcTick,
  input wire logic xtalTick,
  input wire logic lowClockInputPin,
  input wire lsc_pkg::lsc_pwr_t pwr,
  input wire lsc_pkg::lsc_hs_t hs,
  output lsc_pkg::lsc_lmode_t lowModeSel,
  output logic lowNoiseFilterEn,
  output lsc_pkg::lsc_hflt_t highNoiseFilterSel,
  output lsc_pkg::lsc_state_t lowSourceState,
  output logic lowClockReady,
  output logic xtalRun,
  output logic timerXtalClockEn,
  output logic lowClockSwitchIrq,
  output logic highSourceRcFlag,
  output logic lowSourceRcFlag
);
  import lsc_pkg::*;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [15:0] ctrl_reg, ctrl_next;
  logic permit_reg, permit_next;
  logic awHave_reg, awHave_next, wHave_reg, wHave_next;
  logic [17:0] awIdx_reg, awIdx_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] statusByte;

  function automatic logic known(input logic [17:0] idx);
    known = (idx == IDX_CTRL) || (idx == IDX_STAT) || (idx == IDX_AUX);
  endfunction

  assign s_axi_awready = !awHave_reg && !bvalid_reg;
  assign s_axi_wready = !wHave_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  always_comb begin
    logic doWrite;
    logic [15:0] merged;
    doWrite = 1'b0;
    merged = ctrl_reg;
    awHave_next = awHave_reg;
    wHave_next = wHave_reg;
    awIdx_next = awIdx_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    permit_next = permit_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awHave_next = 1'b1;
      awIdx_next = s_axi_awaddr[AXI_AW-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHave_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (awHave_reg && wHave_reg) begin
      doWrite = 1'b1;
      awHave_next = 1'b0;
      wHave_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = known(awIdx_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    // byte lanes 0 and 1 give the byte and halfword access widths
    if (doWrite && awIdx_reg == IDX_CTRL) begin
      if (wStrb_reg[0]) begin
        merged[7:0] = wData_reg[7:0];
      end
      if (wStrb_reg[1]) begin
        merged[15:8] = wData_reg[15:8];
      end
      if (merged[MODE_LSB +: 2] == LM_HOLD) begin
        merged[MODE_LSB +: 2] = ctrl_reg[MODE_LSB +: 2];
      end
      ctrl_next = merged;
    end
    if (doWrite && awIdx_reg == IDX_AUX && wStrb_reg[0]) begin
      permit_next = wData_reg[PERMIT_BIT];
    end
    // status writes fall through with no effect
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      unique case (s_axi_araddr[AXI_AW-1:2])
        IDX_CTRL: rdata_next = {16'h0000, ctrl_reg};
        IDX_STAT: rdata_next = {24'h000000, statusByte};
        IDX_AUX: rdata_next = {24'h000000, 7'h00, permit_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      permit_reg <= AUX_RST;
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awIdx_reg <= 18'h00000;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      permit_reg <= permit_next;
      awHave_reg <= awHave_next;
      wHave_reg <= wHave_next;
      awIdx_reg <= awIdx_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  assign lowModeSel = lsc_lmode_t'(ctrl_reg[MODE_LSB +: 2]);
  // filters are meaningless on the RC paths, so they are gated there
  assign lowNoiseFilterEn = ctrl_reg[LFLT_BIT] && lowModeSel != LM_RC;
  assign highNoiseFilterSel = (hs.highModeSel == LM_RC) ? HF_OFF
                              : lsc_hflt_t'(ctrl_reg[HFLT_LSB +: 2]);

  // ----------------------------------------------------------------
  // low-speed source sequencer
  // ----------------------------------------------------------------
  lsc_state_t state_reg, state_next;
  logic [7:0] rcCnt_reg, rcCnt_next;
  logic [15:0] xtCnt_reg, xtCnt_next;
  logic [4:0] edCnt_reg, edCnt_next;
  logic pinPrev_reg, irq_reg, irq_next, hFlag_reg, hFlag_next;
  logic xtalStable;

  // crystal runs in crystal mode or, in RC mode, when permitted
  assign xtalRun = !pwr.stopMode && (lowModeSel == LM_XTAL
                   || (lowModeSel == LM_RC && permit_reg));
  assign xtalStable = xtCnt_reg == 16'(XtalStabCount);
  assign timerXtalClockEn = xtalRun && xtalStable && lowModeSel == LM_RC;

  always_comb begin
    state_next = state_reg;
    rcCnt_next = rcCnt_reg;
    edCnt_next = edCnt_reg;
    irq_next = 1'b0;
    xtCnt_next = xtCnt_reg;
    if (!xtalRun) begin
      xtCnt_next = 16'h0000;
    end else if (xtalTick && !xtalStable) begin
      xtCnt_next = xtCnt_reg + 16'h0001;
    end
    if (pwr.stopMode) begin
      state_next = LS_RC_WAIT;
      rcCnt_next = 8'h00;
      edCnt_next = 5'h00;
    end else begin
      unique case (state_reg)
        LS_RC_WAIT: begin
          if (rcTick) begin
            rcCnt_next = rcCnt_reg + 8'h01;
          end
          if (rcTick && rcCnt_reg == 8'(RcStartCount - 1)) begin
            state_next = LS_RC;
          end
        end
        LS_RC: begin
          if (lowModeSel == LM_XTAL) begin
            state_next = LS_XTAL_STAB;
          end else if (lowModeSel == LM_EXT) begin
            state_next = LS_EXT_CNT;
            edCnt_next = 5'h00;
          end
        end
        LS_XTAL_STAB: begin
          if (lowModeSel != LM_XTAL) begin
            state_next = LS_RC;
          end else if (xtalStable) begin
            state_next = LS_XTAL;
            irq_next = 1'b1;
          end
        end
        LS_EXT_CNT: begin
          if (lowModeSel != LM_EXT) begin
            state_next = LS_RC;
          end else if (lowClockInputPin && !pinPrev_reg) begin
            edCnt_next = edCnt_reg + 5'h01;
            if (edCnt_reg == 5'(ExtEdgeCount - 1)) begin
              state_next = LS_EXT;
              irq_next = 1'b1;
            end
          end
        end
        // a direct crystal/external swap goes back through the RC state first
        LS_XTAL, LS_EXT: begin
          // each switched state holds only while its own mode stays selected
          if ((state_reg == LS_XTAL) ? (lowModeSel != LM_XTAL) : (lowModeSel != LM_EXT)) begin
            state_next = LS_RC;
          end
        end
        default: state_next = LS_RC_WAIT;
      endcase
    end
    // high source flag follows mode, crystal stability and power state
    hFlag_next = hs.highModeSel == LM_RC
                 || (hs.highModeSel == LM_XTAL && !hs.highXtalStable)
                 || pwr.stopMode || pwr.deepSleepState || pwr.haltHighMode;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= LS_RC_WAIT;
      rcCnt_reg <= 8'h00;
      xtCnt_reg <= 16'h0000;
      edCnt_reg <= 5'h00;
      pinPrev_reg <= 1'b0;
      irq_reg <= 1'b0;
      hFlag_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      rcCnt_reg <= rcCnt_next;
      xtCnt_reg <= xtCnt_next;
      edCnt_reg <= edCnt_next;
      pinPrev_reg <= lowClockInputPin;
      irq_reg <= irq_next;
      hFlag_reg <= hFlag_next;
    end
  end

  assign lowSourceState = state_reg;
  assign lowClockReady = state_reg != LS_RC_WAIT;
  assign lowClockSwitchIrq = irq_reg;
  // flag decoded from the mux state itself, so they never disagree
  assign lowSourceRcFlag = !(state_reg == LS_XTAL || state_reg == LS_EXT);
  assign highSourceRcFlag = hFlag_reg;
  assign statusByte = STAT_RST & {5'h00, lowSourceRcFlag, highSourceRcFlag, 1'b0};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_hold_mode;
    @(posedge clk_sys) disable iff (rst)
      (awHave_reg && wHave_reg && awIdx_reg == IDX_CTRL && wStrb_reg[0]
       && wData_reg[1:0] == 2'b00) |=> $stable(ctrl_reg[1:0]);
  endproperty
  a_hold_mode: assert property (p_hold_mode) else $error("mode changed on 00");

  property p_mode_legal;
    @(posedge clk_sys) disable iff (rst) lowModeSel != LM_HOLD;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("mode field is 00");

  property p_lflt;
    @(posedge clk_sys) disable iff (rst)
      lowNoiseFilterEn |-> (ctrl_reg[4] && lowModeSel != LM_RC);
  endproperty
  a_lflt: assert property (p_lflt) else $error("low filter on wrongly");

  property p_stat_write;
    @(posedge clk_sys) disable iff (rst)
      (awHave_reg && wHave_reg && awIdx_reg == IDX_STAT) |=> $stable(ctrl_reg);
  endproperty
  a_stat_write: assert property (p_stat_write) else $error("status write hit ctrl");

  property p_stat_bits;
    @(posedge clk_sys) disable iff (rst) statusByte[7:3] == 5'h00 && !statusByte[0];
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("unused status bit set");

  property p_high_pwr;
    @(posedge clk_sys) disable iff (rst)
      (pwr.stopMode || pwr.deepSleepState || pwr.haltHighMode) |=> highSourceRcFlag;
  endproperty
  a_high_pwr: assert property (p_high_pwr) else $error("high flag low in power-down");

  property p_high_run;
    @(posedge clk_sys) disable iff (rst)
      (hs.highModeSel == LM_EXT && !pwr.stopMode && !pwr.deepSleepState
       && !pwr.haltHighMode) |=> !highSourceRcFlag;
  endproperty
  a_high_run: assert property (p_high_run) else $error("high flag high on ext");

  property p_stop_low;
    @(posedge clk_sys) disable iff (rst) pwr.stopMode |=> lowSourceRcFlag && !lowClockReady;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("low flag low after stop");

  sequence s_switch;
    $rose(!lowSourceRcFlag);
  endsequence
  property p_switch_irq;
    @(posedge clk_sys) disable iff (rst) s_switch |-> lowClockSwitchIrq;
  endproperty
  a_switch_irq: assert property (p_switch_irq) else $error("switch without event");

  property p_ready_count;
    @(posedge clk_sys) disable iff (rst) $rose(lowClockReady) |-> $past(rcCnt_reg) == 8'(RcStartCount - 1);
  endproperty
  a_ready_count: assert property (p_ready_count) else $error("RC ready early");
endmodule // lsc_low_clock_ctrl
`default_nettype wire

// ### verification/lsc_low_clock_partner.sv
// far-side model: low-speed crystal and external low clock source
`timescale 1ns/1ps
`default_nettype none
module lsc_low_clock_partner (
  input wire logic clk_sys,
  input wire logic xtalRun,
  input wire logic extEn,
  input wire logic [3:0] div,
  output logic xtalTick,
  output logic lowClockInputPin
);
  logic [3:0] cntReg = 4'h0;
  initial xtalTick = 1'b0;
  initial lowClockInputPin = 1'b0;
  // crystal ticks only while enabled; pin is held at a level when no clock is fed
  always @(posedge clk_sys) begin
    cntReg <= (cntReg >= div) ? 4'h0 : cntReg + 4'h1;
    xtalTick <= xtalRun && (cntReg == div);
    if (!extEn) begin
      lowClockInputPin <= 1'b0;
    end else if (cntReg == div) begin
      lowClockInputPin <= !lowClockInputPin;
    end
  end
endmodule // lsc_low_clock_partner
`default_nettype wire

// ### verification/lsc_low_clock_ctrl_tb.sv
// testbench: register access, low clock sequencing and status flags
`timescale 1ns/1ps
`default_nettype none
module lsc_low_clock_ctrl_tb;
  import lsc_pkg::*;
  localparam int XTAL_N = 16;
  localparam int RC_N = 4;
  localparam int EXT_N = 4;
  localparam logic [19:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [19:0] A_STAT = {IDX_STAT, 2'b00};
  localparam logic [19:0] A_AUX = {IDX_AUX, 2'b00};
  localparam logic [2:0] HS [6] = '{3'h3, 3'h2, 3'h5, 3'h3, 3'h3, 3'h6};
  localparam logic [2:0] PW [6] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h0};
  localparam logic [5:0] HEXP = 6'h1E;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, rcTick = 0, extEn = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, rcDiv = 2'h0;
  logic [31:0] s_axi_rdata, rd, d;
  logic [3:0] div = 4'h3;
  logic xtalTick, lowClockInputPin, lowNoiseFilterEn, lowClockReady, xtalRun;
  logic timerXtalClockEn, lowClockSwitchIrq, highSourceRcFlag, lowSourceRcFlag;
  lsc_pwr_t pwr = '0;
  lsc_hs_t hs = 3'h4;
  lsc_lmode_t lowModeSel;
  lsc_hflt_t highNoiseFilterSel;
  lsc_state_t lowSourceState;
  int errors = 0;
  int comparisons = 0;
  int c;
  logic [31:0] seed = 32'h716CFAE6;
  logic [15:0] ctrlExp = CTRL_RST;

  always #12.5 clk_sys = ~clk_sys;
  // built-in rc oscillator stand-in: one tick every fourth cycle
  always @(posedge clk_sys) begin
    rcDiv <= rcDiv + 2'h1;
    rcTick <= (rcDiv == 2'h3);
  end

  lsc_low_clock_ctrl #(.XtalStabCount(XTAL_N), .RcStartCount(RC_N), .ExtEdgeCount(EXT_N)) dut (
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rcTick, .xtalTick, .lowClockInputPin, .pwr, .hs, .lowModeSel, .lowNoiseFilterEn,
    .highNoiseFilterSel, .lowSourceState, .lowClockReady, .xtalRun, .timerXtalClockEn,
    .lowClockSwitchIrq, .highSourceRcFlag, .lowSourceRcFlag);
  lsc_low_clock_partner peer (.clk_sys, .xtalRun, .extEn, .div, .xtalTick, .lowClockInputPin);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // mode code 00 leaves the held mode in place
  function automatic logic [15:0] nxt(input logic [15:0] o, input logic [31:0] v,
                                      input logic [3:0] s);
    logic [15:0] n;
    n = o;
    if (s[0]) n[7:0] = (v[1:0] == 2'b00) ? {v[7:2], o[1:0]} : v[7:0];
    if (s[1]) n[15:8] = v[15:8];
    return n;
  endfunction
  function automatic logic sig(input int w);
    return (w == 0) ? lowClockReady : (w == 1) ? lowClockSwitchIrq : timerXtalClockEn;
  endfunction
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 200) begin
      errors++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] v, input logic [3:0] s);
    int k;
    @(posedge clk_sys);
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 200);
    tmo(k);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [19:0] a);
    int k;
    @(posedge clk_sys);
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 200);
    tmo(k);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic waitSig(input int w);
    int k;
    k = 0;
    while (sig(w) !== 1'b1 && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    tmo(k);
  endtask
  // counts crystal ticks or input rising edges up to the switch event
  task automatic untilSwitch(input bit ext, output int n);
    int k;
    logic prev;
    n = 0;
    k = 0;
    prev = lowClockInputPin;
    do begin
      @(posedge clk_sys);
      k++;
      if (ext ? (lowClockInputPin && !prev) : xtalTick) n++;
      prev = lowClockInputPin;
    end while (lowClockSwitchIrq !== 1'b1 && k < 200);
    tmo(k);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    chk(lowClockReady, 1'b0, "ready in reset");
    c = 0;
    for (int k = 0; k < 200 && lowClockReady !== 1'b1; k++) begin
      @(posedge clk_sys);
      if (lowClockReady !== 1'b1 && rcTick) c++;
    end
    chk(c, RC_N, "rc ticks before ready");
    rdr(A_CTRL);
    chk(rd, {16'h0, CTRL_RST}, "ctrl reset");
    rdr(A_STAT);
    chk(rd, {24'h0, STAT_RST}, "status reset");
    chk(lowModeSel, LM_RC, "reset mode");
    hs <= 3'h3;
    wr(A_CTRL, 32'h0000_00FC, 4'h1);
    ctrlExp = nxt(ctrlExp, 32'h0000_00FC, 4'h1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = {seed[31:2], seed[1], 1'b0};
      wr(A_CTRL, d, seed[9:6]);
      ctrlExp = nxt(ctrlExp, d, seed[9:6]);
      rdr(A_CTRL);
      chk(rd, {16'h0, ctrlExp}, "ctrl readback");
      chk(lowModeSel, LM_RC, "mode held");
      chk(lowNoiseFilterEn, 1'b0, "low filter in rc");
    end
    // last code set is filter one, the one fit for a 16 MHz high clock
    for (int j = 0; j < 4; j++) begin
      d = {24'h0, 2'(j * 3), 6'h12};
      wr(A_CTRL, d, 4'h1);
      chk(highNoiseFilterSel, d[7:6], "high filter code");
    end
    wr(A_CTRL, 32'h0000_0011, 4'h1);
    chk(xtalRun, 1'b1, "crystal enabled");
    chk(lowNoiseFilterEn, 1'b1, "low filter in crystal");
    untilSwitch(1'b0, c);
    chk(c, XTAL_N, "crystal count");
    chk(lowSourceRcFlag, 1'b0, "flag drops with switch");
    chk(lowSourceState, LS_XTAL, "state on crystal");
    @(posedge clk_sys);
    chk(lowClockSwitchIrq, 1'b0, "switch event one cycle");
    rdr(A_STAT);
    chk(rd, 32'h0, "status on crystal");
    wr(A_CTRL, 32'h0000_0012, 4'h1);
    repeat (2) @(posedge clk_sys);
    chk(lowSourceRcFlag, 1'b1, "flag back on rc");
    div <= 4'h7;
    wr(A_CTRL, 32'h0000_0013, 4'h1);
    extEn <= 1'b1;
    untilSwitch(1'b1, c);
    chk(c, EXT_N, "input edge count");
    chk(lowSourceRcFlag, 1'b0, "flag on external");
    chk(lowSourceState, LS_EXT, "state on external");
    wr(A_CTRL, 32'h0000_0012, 4'h1);
    extEn <= 1'b0;
    div <= 4'h3;
    wr(A_AUX, 32'h1, 4'hF);
    chk(xtalRun, 1'b1, "permit runs crystal");
    waitSig(2);
    chk(lowSourceRcFlag, 1'b1, "rc still feeds peripherals");
    chk(lowSourceState, LS_RC, "state back on rc");
    wr(A_STAT, 32'hFF, 4'hF);
    chk(resp, RESP_OKAY, "status write resp");
    rdr(A_STAT);
    chk(rd, 32'h4, "status unchanged");
    chk(lowModeSel, LM_RC, "mode unchanged");
    rdr(20'h00100);
    chk(resp, RESP_SLVERR, "unmapped read resp");
    chk(rd, 32'h0, "unmapped read data");
    wr(20'h00100, 32'hFFFF_FFFF, 4'hF);
    chk(resp, RESP_SLVERR, "unmapped write");
    for (int i = 0; i < 6; i++) begin
      hs <= HS[i];
      pwr <= PW[i];
      repeat (2) @(posedge clk_sys);
      chk(highSourceRcFlag, HEXP[i], "high source flag");
    end
    pwr <= '0;
    wr(A_CTRL, 32'h0000_0001, 4'h1);
    waitSig(1);
    pwr <= 3'h4;
    repeat (2) @(posedge clk_sys);
    chk({lowSourceRcFlag, highSourceRcFlag}, 2'b11, "flags in stop");
    pwr <= '0;
    close_out();
  end
endmodule // lsc_low_clock_ctrl_tb
`default_nettype wire
